// >>> sbc_pkg.sv
// Shared constants and types of the sensorless commutator
`default_nettype none

package sbc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 10_000_000;
    localparam int unsigned FORCE_DIV_EXP = 17;
    // One forced step lasts 2^17 clocks, six steps per electrical turn
    localparam int unsigned FORCE_STEP_CYCLES = 1 << FORCE_DIV_EXP;
    localparam int unsigned STOP_CYCLES = 1 << FORCE_DIV_EXP;
    localparam int unsigned LAP_CYCLES = 64;
    localparam int unsigned PERIOD_W = 20;
    localparam logic [2:0] NUM_STEPS_M1 = 3'h5;

    // ------------------------------------------------------------
    // APB register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] PERIOD_OFS = 12'h008;

    // Control fields
    localparam int unsigned CTRL_W = 5;
    localparam int unsigned CTRL_LEAD_LSB_BIT = 0;
    localparam int unsigned CTRL_LEAD_MSB_BIT = 1;
    localparam int unsigned CTRL_DIR_BIT = 2;
    localparam int unsigned CTRL_ALT_BIT = 3;
    localparam int unsigned CTRL_NO_LAP_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h10;

    // Status fields
    localparam int unsigned ST_STATE_LSB = 0;
    localparam int unsigned ST_STEP_LSB = 3;
    localparam int unsigned ST_LEAD_LSB = 6;
    localparam int unsigned ST_OCBLK_BIT = 8;

    // ------------------------------------------------------------
    // Operating states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SBC_IDLE = 3'b001,
        SBC_FORCED = 3'b010,
        SBC_SENSED = 3'b100
    } sbc_state_e;

endpackage

`default_nettype wire

// >>> sbc_edge_det.sv
// Level register with rise and fall detection
`default_nettype none

module sbc_edge_det #(
    parameter logic RST_LVL = 1'b0
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic level_in,
    output logic rise_out,
    output logic fall_out
);

    typedef struct packed {
        logic lvl;
    } sbc_edge_s;

    sbc_edge_s q;
    sbc_edge_s d;

    always_comb begin
        d = q;
        d.lvl = level_in;
        rise_out = level_in & ~q.lvl;
        fall_out = ~level_in & q.lvl;
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            q <= '{lvl: RST_LVL};
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

// >>> sbc_down_timer.sv
// Loadable down counter with one-cycle expiry pulse
`default_nettype none

module sbc_down_timer #(
    parameter int unsigned W = 20
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic load_in,
    input wire logic [W-1:0] value_in,
    output logic expired_out,
    output logic busy_out
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic run;
        logic exp;
    } sbc_tmr_s;

    sbc_tmr_s q;
    sbc_tmr_s d;

    if (W < 2) begin : g_bad_width
        $error("sbc_down_timer: W must be at least 2");
    end

    always_comb begin
        d = q;
        d.exp = 1'b0;
        if (load_in) begin
            // Zero is served as one cycle
            d.cnt = (value_in == '0) ? {{(W-1){1'b0}}, 1'b1} : value_in;
            d.run = 1'b1;
        end else if (q.run) begin
            d.cnt = q.cnt - 1'b1;
            if (q.cnt == {{(W-1){1'b0}}, 1'b1}) begin
                d.run = 1'b0;
                d.exp = 1'b1;
            end
        end
        expired_out = q.exp;
        busy_out = q.run;
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

// >>> sbc_commutator.sv
// Three-phase sensorless commutator core with APB control
`default_nettype none

//
// Contract
// - Lead select bits map to 0, 7.5, 15 or 30 degrees
// - PWM input low means the chopped switches are on
// - Low direction runs U V W; high runs U W V
// - Chop high side only, or alternate high and low side
// - Overlap select high gives 120 degree; low gives overlapped turn-on
// - Forced steps every 2^17 clocks, six steps per turn
// - High-side outputs are low to switch on
// - Low-side outputs are high to switch on
// - Overcurrent high restricts the chopped switch
// - Rotor position comes from one majority-logic sense input
// - Overcurrent rise turns chopped phase off until next PWM cycle
// - Position sense sampled at PWM rising edges
// - Zero lead while forced, selected lead after; 30 stays 30
// - Start forced, switch to back-EMF timing on valid transitions
module sbc_commutator #(
    parameter int unsigned PW = sbc_pkg::PERIOD_W,
    parameter int unsigned FORCE_STEP_CYCLES = sbc_pkg::FORCE_STEP_CYCLES,
    parameter int unsigned STOP_CYCLES = sbc_pkg::STOP_CYCLES,
    parameter int unsigned LAP_CYCLES = sbc_pkg::LAP_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [11:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic pwm_n_in,
    input wire logic position_sense_in,
    input wire logic overcurrent_in,
    output logic u_high_side_drive_n_out,
    output logic v_high_side_drive_n_out,
    output logic w_high_side_drive_n_out,
    output logic u_low_side_drive_out,
    output logic v_low_side_drive_out,
    output logic w_low_side_drive_out
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (PW < 8 || PW > 24) begin : g_bad_pw
        $error("sbc_commutator: PW must lie in 8..24");
    end
    if (FORCE_STEP_CYCLES < 2 || FORCE_STEP_CYCLES >= (1 << PW)) begin : g_bad_force
        $error("sbc_commutator: FORCE_STEP_CYCLES does not fit PW");
    end
    if (STOP_CYCLES < 2 || STOP_CYCLES >= (1 << PW)) begin : g_bad_stop
        $error("sbc_commutator: STOP_CYCLES does not fit PW");
    end
    if (LAP_CYCLES < 1 || LAP_CYCLES >= (1 << PW)) begin : g_bad_lap
        $error("sbc_commutator: LAP_CYCLES does not fit PW");
    end

    localparam logic [PW-1:0] FORCE_VAL = PW'(FORCE_STEP_CYCLES);
    // Expiry pulse lands one cycle after the count runs out
    localparam logic [PW-1:0] FORCE_LOAD = PW'(FORCE_STEP_CYCLES - 1);
    localparam logic [PW-1:0] STOP_VAL = PW'(STOP_CYCLES);
    localparam logic [PW-1:0] LAP_VAL = PW'(LAP_CYCLES);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        sbc_pkg::sbc_state_e state;
        logic [2:0] step;
        logic [sbc_pkg::CTRL_W-1:0] ctrl;
        logic [31:0] rdata;
        logic [2:0] hi_n;
        logic [2:0] lo;
        logic [5:0] prev_pat;
        logic oc_blk;
        logic ref_wave;
        logic samp_wave;
        logic cand;
        logic zc_seen;
        logic [1:0] zc_cnt;
        logic [PW-1:0] per_cnt;
        logic [PW-1:0] per_q;
        logic [PW-1:0] since;
    } sbc_core_s;

    sbc_core_s q;
    sbc_core_s d;

    logic pwm_rise;
    logic pwm_fall;
    logic oc_rise;
    logic force_exp;
    logic dly_exp;
    logic dly_busy;
    logic stop_exp;
    logic lap_busy;
    logic force_load;
    logic dly_load;
    logic lap_load;
    logic [PW-1:0] dly_val;
    logic zc;
    logic commute;
    logic tgt_sensed;
    logic lead_both;
    logic [1:0] lead_code;
    logic [1:0] lead_eff;
    logic [5:0] pat;
    logic gate;
    logic chop_hi;
    logic chop_lo;
    logic [2:0] hi_on;
    logic [2:0] lo_on;
    logic apb_hit;

    // ------------------------------------------------------------
    // Edge detectors and timers
    // ------------------------------------------------------------
    sbc_edge_det #(.RST_LVL(1'b1)) u_pwm_edge (
        .clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .level_in(pwm_n_in),
        .rise_out(pwm_rise),
        .fall_out(pwm_fall)
    );

    sbc_edge_det #(.RST_LVL(1'b1)) u_oc_edge (
        .clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .level_in(overcurrent_in),
        .rise_out(oc_rise),
        .fall_out()
    );

    sbc_down_timer #(.W(PW)) u_force_tmr (
        .clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .load_in(force_load),
        .value_in(FORCE_LOAD),
        .expired_out(force_exp),
        .busy_out()
    );

    sbc_down_timer #(.W(PW)) u_delay_tmr (
        .clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .load_in(dly_load),
        .value_in(dly_val),
        .expired_out(dly_exp),
        .busy_out(dly_busy)
    );

    sbc_down_timer #(.W(PW)) u_stop_tmr (
        .clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .load_in(pwm_fall),
        .value_in(STOP_VAL),
        .expired_out(stop_exp),
        .busy_out()
    );

    sbc_down_timer #(.W(PW)) u_lap_tmr (
        .clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .load_in(lap_load),
        .value_in(LAP_VAL),
        .expired_out(),
        .busy_out(lap_busy)
    );

    // ------------------------------------------------------------
    // Step pattern, bit 0 = U, 1 = V, 2 = W; returns {high, low}
    // ------------------------------------------------------------
    function automatic logic [5:0] step_pat(input logic [2:0] st, input logic rev);
        logic [2:0] h;
        logic [2:0] l;
        case (st)
            3'h0: begin h = 3'h1; l = 3'h2; end
            3'h1: begin h = 3'h1; l = 3'h4; end
            3'h2: begin h = 3'h2; l = 3'h4; end
            3'h3: begin h = 3'h2; l = 3'h1; end
            3'h4: begin h = 3'h4; l = 3'h1; end
            default: begin h = 3'h4; l = 3'h2; end
        endcase
        // Reverse swaps V and W
        if (rev) begin
            h = {h[1], h[2], h[0]};
            l = {l[1], l[2], l[0]};
        end
        return {h, l};
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        lead_code = {q.ctrl[sbc_pkg::CTRL_LEAD_MSB_BIT], q.ctrl[sbc_pkg::CTRL_LEAD_LSB_BIT]};
        lead_both = &lead_code;
        lead_eff = (q.state == sbc_pkg::SBC_SENSED || lead_both) ? lead_code : 2'h0;
        tgt_sensed = (q.state == sbc_pkg::SBC_SENSED) ||
                     (q.state == sbc_pkg::SBC_FORCED && q.zc_cnt == 2'h1);

        // Sense sampled at PWM rising edges; two in a row confirm a crossing
        zc = 1'b0;
        if (pwm_rise) begin
            d.samp_wave = position_sense_in;
            if (q.state != sbc_pkg::SBC_IDLE && !q.zc_seen && !dly_busy) begin
                if (position_sense_in != q.ref_wave) begin
                    d.cand = 1'b1;
                    zc = q.cand;
                end else begin
                    d.cand = 1'b0;
                end
            end
        end

        // Step period measurement
        d.per_cnt = (&q.per_cnt) ? q.per_cnt : q.per_cnt + 1'b1;
        if (zc) begin
            d.per_q = q.per_cnt;
            d.per_cnt = '0;
            d.zc_seen = 1'b1;
            d.cand = 1'b0;
        end

        // Delay from crossing to commutation: (30 - lead) of a 60 degree step
        case (lead_code)
            2'h0: dly_val = q.per_cnt >> 1;
            2'h1: dly_val = (q.per_cnt >> 2) + (q.per_cnt >> 3);
            2'h2: dly_val = q.per_cnt >> 2;
            default: dly_val = '0;
        endcase
        dly_load = zc && tgt_sensed && !lead_both;
        commute = (q.state != sbc_pkg::SBC_IDLE && force_exp) ||
                  (q.state == sbc_pkg::SBC_SENSED && dly_exp) ||
                  (zc && tgt_sensed && lead_both);

        // Mode sequencing
        case (q.state)
            sbc_pkg::SBC_IDLE: begin
                if (pwm_fall) begin
                    d.state = sbc_pkg::SBC_FORCED;
                    d.step = 3'h0;
                    d.zc_cnt = 2'h0;
                    d.zc_seen = 1'b0;
                    d.cand = 1'b0;
                    d.ref_wave = q.samp_wave;
                end
            end
            sbc_pkg::SBC_FORCED: begin
                if (zc) begin
                    if (q.zc_cnt == 2'h1) begin
                        d.state = sbc_pkg::SBC_SENSED;
                    end else begin
                        d.zc_cnt = q.zc_cnt + 2'h1;
                    end
                end
            end
            sbc_pkg::SBC_SENSED: begin
                // Lost crossings fall back to forced stepping
                if (force_exp) begin
                    d.state = sbc_pkg::SBC_FORCED;
                    d.zc_cnt = 2'h0;
                end
            end
            default: begin
                d.state = sbc_pkg::SBC_IDLE;
            end
        endcase
        if (stop_exp) begin
            d.state = sbc_pkg::SBC_IDLE;
        end

        pat = step_pat(q.step, q.ctrl[sbc_pkg::CTRL_DIR_BIT]);
        if (commute) begin
            d.step = (q.step == sbc_pkg::NUM_STEPS_M1) ? 3'h0 : q.step + 3'h1;
            d.ref_wave = q.samp_wave;
            d.zc_seen = 1'b0;
            d.cand = 1'b0;
            d.prev_pat = pat;
        end
        force_load = commute || (q.state == sbc_pkg::SBC_IDLE && pwm_fall);
        lap_load = commute && !q.ctrl[sbc_pkg::CTRL_NO_LAP_BIT];
        d.since = force_load ? '0 : q.since + 1'b1;

        // Overcurrent block; a new rise wins over the clear
        if (pwm_fall) begin
            d.oc_blk = 1'b0;
        end
        if (oc_rise) begin
            d.oc_blk = 1'b1;
        end

        // Output synthesis
        gate = ~pwm_n_in & ~q.oc_blk;
        chop_hi = ~q.ctrl[sbc_pkg::CTRL_ALT_BIT] | ~q.step[0];
        chop_lo = q.ctrl[sbc_pkg::CTRL_ALT_BIT] & q.step[0];
        hi_on = pat[5:3] & {3{gate | ~chop_hi}};
        lo_on = pat[2:0] & {3{gate | ~chop_lo}};
        if (lap_busy) begin
            hi_on = hi_on | (q.prev_pat[5:3] & {3{gate}});
            lo_on = lo_on | (q.prev_pat[2:0] & {3{gate}});
        end
        lo_on = lo_on & ~hi_on;
        if (q.state == sbc_pkg::SBC_IDLE) begin
            hi_on = 3'h0;
            lo_on = 3'h0;
        end
        d.hi_n = ~hi_on;
        d.lo = lo_on;

        // APB slave, no wait states; read data captured in setup
        apb_hit = (paddr_in == sbc_pkg::CTRL_OFS) || (paddr_in == sbc_pkg::STATUS_OFS) ||
                  (paddr_in == sbc_pkg::PERIOD_OFS);
        if (psel_in && !penable_in) begin
            d.rdata = 32'h00000000;
            case (paddr_in)
                sbc_pkg::CTRL_OFS: begin
                    d.rdata[sbc_pkg::CTRL_W-1:0] = q.ctrl;
                end
                sbc_pkg::STATUS_OFS: begin
                    d.rdata[sbc_pkg::ST_STATE_LSB +: 3] = q.state;
                    d.rdata[sbc_pkg::ST_STEP_LSB +: 3] = q.step;
                    d.rdata[sbc_pkg::ST_LEAD_LSB +: 2] = lead_eff;
                    d.rdata[sbc_pkg::ST_OCBLK_BIT] = q.oc_blk;
                end
                sbc_pkg::PERIOD_OFS: begin
                    d.rdata[PW-1:0] = q.per_q;
                end
                default: begin
                    d.rdata = 32'h00000000;
                end
            endcase
        end
        if (psel_in && penable_in && pwrite_in && paddr_in == sbc_pkg::CTRL_OFS) begin
            d.ctrl = pwdata_in[sbc_pkg::CTRL_W-1:0];
        end
        pready_out = 1'b1;
        pslverr_out = psel_in & penable_in & ~apb_hit;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            q <= '0;
            q.state <= sbc_pkg::SBC_IDLE;
            q.ctrl <= sbc_pkg::CTRL_RESET;
            q.hi_n <= 3'h7;
            // Sense line idles high
            q.samp_wave <= 1'b1;
            q.ref_wave <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata_out = q.rdata;
    assign u_high_side_drive_n_out = q.hi_n[0];
    assign v_high_side_drive_n_out = q.hi_n[1];
    assign w_high_side_drive_n_out = q.hi_n[2];
    assign u_low_side_drive_out = q.lo[0];
    assign v_low_side_drive_out = q.lo[1];
    assign w_low_side_drive_out = q.lo[2];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb_main @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);

    AST_IDLE_ALL_OFF: assert property (
        q.state == sbc_pkg::SBC_IDLE |=> (q.hi_n == 3'h7 && q.lo == 3'h0))
        else $error("drives not off in idle");

    AST_PWM_OFF_HIGH: assert property (
        (q.state != sbc_pkg::SBC_IDLE && pwm_n_in && !lap_busy &&
         !q.ctrl[sbc_pkg::CTRL_ALT_BIT]) |=> q.hi_n == 3'h7)
        else $error("high side on while PWM is off");

    AST_ONE_PAIR: assert property (
        (q.state != sbc_pkg::SBC_IDLE && gate && !lap_busy) |=>
        ($countones(~q.hi_n) == 1 && $countones(q.lo) == 1 && (~q.hi_n & q.lo) == 3'h0))
        else $error("not one high and one low of different phases");

    AST_LOW_UNCHOPPED: assert property (
        (q.state != sbc_pkg::SBC_IDLE && !gate && !lap_busy &&
         !q.ctrl[sbc_pkg::CTRL_ALT_BIT]) |=> $countones(q.lo) == 1)
        else $error("low side chopped in high-side chopping style");

    AST_DIR_STEP1: assert property (
        (q.state != sbc_pkg::SBC_IDLE && q.step == 3'h1 && gate && !lap_busy) |=>
        (q.lo == (q.ctrl[sbc_pkg::CTRL_DIR_BIT] ? 3'h2 : 3'h4)))
        else $error("wrong low phase in step one for direction");

    AST_FORCE_RATE: assert property (
        force_exp |-> q.since == FORCE_VAL - 1'b1)
        else $error("forced step interval wrong");

    AST_OC_BLOCKS: assert property (
        (oc_rise && !pwm_fall) |=> q.oc_blk ##1 (lap_busy || q.ctrl[sbc_pkg::CTRL_ALT_BIT] ||
         q.hi_n == 3'h7))
        else $error("overcurrent did not switch off chopped side");

    AST_OC_RELEASE: assert property (
        (q.oc_blk && pwm_fall && !oc_rise) |=> !q.oc_blk)
        else $error("overcurrent block not cleared at next PWM cycle");

    AST_ZC_AT_PWM_RISE: assert property (
        zc |-> (pwm_rise && position_sense_in != q.ref_wave && $past(pwm_n_in) == 1'b0))
        else $error("crossing taken outside a PWM rising edge");

    AST_TO_SENSED: assert property (
        (q.state == sbc_pkg::SBC_FORCED && zc && q.zc_cnt == 2'h1 && !stop_exp &&
         !force_exp) |=> q.state == sbc_pkg::SBC_SENSED)
        else $error("no switch to sensed timing");

    AST_LEAD30_NOW: assert property (
        (zc && tgt_sensed && lead_both) |-> commute ##1 !dly_busy)
        else $error("30 degree lead did not commute at crossing");

    AST_FORCED_LEAD: assert property (
        (q.state == sbc_pkg::SBC_FORCED && !lead_both) |-> lead_eff == 2'h0)
        else $error("nonzero lead during forced start");

    AST_LAP_ONLY_SEL: assert property (
        q.ctrl[sbc_pkg::CTRL_NO_LAP_BIT] && commute |=> !lap_busy)
        else $error("overlap active in 120 degree mode");

    AST_LAP_ON_SEL: assert property (
        (!q.ctrl[sbc_pkg::CTRL_NO_LAP_BIT] && commute) |=> lap_busy)
        else $error("overlap missing in lap turn-on mode");

    COV_SENSED: cover property (q.state == sbc_pkg::SBC_FORCED ##1 q.state == sbc_pkg::SBC_SENSED);
    COV_OC: cover property (oc_rise ##1 q.oc_blk ##[1:100] !q.oc_blk);
    COV_LAP: cover property (lap_load ##1 lap_busy);
    COV_STOP: cover property (q.state != sbc_pkg::SBC_IDLE ##1 q.state == sbc_pkg::SBC_IDLE);

endmodule

`default_nettype wire

// >>> sbc_motor_model.sv
// Spinning motor model that drives the position sense line
`default_nettype none

module sbc_motor_model #(
    parameter int HALF = 64
) (
    input wire logic clk_in,
    input wire logic en_in,
    output logic sense_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial sense_out = 1'h1;
    // Majority sense flips every HALF clocks; pulled high when stopped
    always @(posedge clk_in) begin
        if (!en_in) begin
            cnt <= 0;
            sense_out <= 1'h1;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            sense_out <= !sense_out;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

`default_nettype wire

// >>> test_sensorless_bldc_commutator.sv
// Self-checking bench of the sensorless commutator
`default_nettype none

module test_sensorless_bldc_commutator;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, rstn = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, drv;
    logic pready, pslverr, err, sense, uh, vh, wh, ul, vl, wl;
    logic pwm_n = 1'h1, oc = 1'h0, pwm_en = 1'h0, mot_en = 1'h0, pwm_prev = 1'h1;
    int fail_count = 0, n_compared = 0, cyc = 0, cnt = 0, lowlen = 3, seed = 48192;

    always #50 clk = ~clk;
    assign drv = {26'h0, uh, vh, wh, ul, vl, wl};

    sbc_commutator #(.FORCE_STEP_CYCLES(64), .STOP_CYCLES(200), .LAP_CYCLES(4)) dut_u (
        .ref_clk_in(clk), .resetn_in(rstn), .paddr_in(paddr), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .pwm_n_in(pwm_n),
        .position_sense_in(sense), .overcurrent_in(oc), .u_high_side_drive_n_out(uh),
        .v_high_side_drive_n_out(vh), .w_high_side_drive_n_out(wh),
        .u_low_side_drive_out(ul), .v_low_side_drive_out(vl), .w_low_side_drive_out(wl));

    // Crossings come faster than forced steps
    sbc_motor_model #(.HALF(48)) motor_u (.clk_in(clk), .en_in(mot_en), .sense_out(sense));

    // ------------------------------------------------------------
    // Stimulus and helpers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count = fail_count + 1;
            test_done();
        end
        if (pwm_en) begin
            pwm_n <= (cnt % 8) >= lowlen; // At least 3 high clocks of 100 ns
            oc <= (cnt % 64) == 41;
            cnt <= cnt + 1;
            if (cnt % 8 == 7) lowlen <= 3 + ($unsigned($random(seed)) % 3);
        end else begin
            pwm_n <= 1'h1;
            oc <= 1'h0;
            cnt <= 0;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pen <= 1'h0;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask

    function automatic logic [31:0] pat(int s, bit rev, bit on, bit alt);
        int hi, lo;
        logic [2:0] h, l;
        hi = s / 2;
        lo = (s == 0 || s == 5) ? 1 : (s < 3 ? 2 : 0);
        if (rev) begin
            hi = (3 - hi) % 3;
            lo = (3 - lo) % 3;
        end
        h = 3'h4 >> hi;
        l = 3'h4 >> lo;
        if (!on && !(alt && s % 2 == 1)) h = 3'h0;
        if (!on && alt && s % 2 == 1) l = 3'h0;
        return {26'h0, ~h, l};
    endfunction

    task automatic watch(input bit rev, input bit alt);
        int k, m;
        while (cnt < 390) begin
            @(negedge clk);
            k = cnt - 1;
            m = k % 64;
            if (m >= 45 && m <= 47) begin
                chk(drv, pat(k / 64 % 6, rev, 1'h0, alt));
            end else if (m >= 4 && m <= 60 && (m < 41 || m > 51)) begin
                chk(drv, pat(k / 64 % 6, rev, !pwm_prev, alt));
            end
            pwm_prev = pwm_n;
        end
    endtask

    task automatic test_done();
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        @(negedge clk);
        chk(drv, 32'h38);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h10);
        apb(1'h0, 12'h004, 32'h0);
        chk(rd, 32'h1);
        apb(1'h0, 12'h00C, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        pwm_en <= 1'h1;
        watch(1'h0, 1'h0);
        pwm_en <= 1'h0;
        repeat (210) @(posedge clk);
        @(negedge clk);
        chk(drv, 32'h38);
        apb(1'h1, 12'h000, 32'h1C);
        apb(1'h0, 12'h004, 32'h0);
        // Idle, stopped after nine forced steps in step 3
        chk(rd, 32'h19);
        pwm_en <= 1'h1;
        watch(1'h1, 1'h1);
        for (int c = 0; c < 4; c++) begin
            // Last setting turns lap on for the sensed run
            apb(1'h1, 12'h000, {27'h0, (c != 3), 2'($random(seed)), 2'(c)});
            apb(1'h0, 12'h004, 32'h0);
            chk({30'h0, rd[7:6]}, (c == 3) ? 32'h3 : 32'h0);
        end
        mot_en <= 1'h1;
        rd = 32'h0;
        for (int i = 0; i < 60 && rd[2:0] !== 3'h4; i++) begin
            repeat (20) @(posedge clk);
            apb(1'h0, 12'h004, 32'h0);
        end
        chk({29'h0, rd[2:0]}, 32'h4);
        apb(1'h1, 12'h000, 32'h11);
        apb(1'h0, 12'h004, 32'h0);
        chk({30'h0, rd[7:6]}, 32'h1);
        test_done();
    end
endmodule

`default_nettype wire
